// [hw/adc_bus_consts.svh]
// Constants for the shared SRAM capture and bus handover block
`ifndef ADC_BUS_CONSTS_SVH
`define ADC_BUS_CONSTS_SVH
`define DATA_W 16
`define ADDR_W 23
`define FIFO_DEPTH 16
`define CH_COUNT 8
`define CH_COUNT_W 3
`define BIT_COUNT_W 4
`define BIT_LAST 4'hf
`define ADDR_ZERO 23'h000000
`define ADDR_ONE 23'h000001
`define CH_SPAN 23'h000008
`define CH_TOP 23'h000007
`define CH_LAST 3'h7
`define CH_FIRST 3'h0
`endif

// [hw/adc_bus_pkg.sv]
// Types for the shared SRAM capture and bus handover block
package adc_bus_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW = 3'b001,
    ST_HIGH = 3'b010,
    ST_WAIT = 3'b011,
    ST_STORE = 3'b100,
    ST_DONE = 3'b101
  } cap_state_e;
endpackage

// [hw/sample_fifo.sv]
// Parameterised valid/ready FIFO for conversion words
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (clk_en && push)
      mem_q[wp_q] <= in_data;
  end
endmodule

// [hw/adc_sram_bus_handover.sv]
// Capture engine sharing one SRAM with the host, and the bus handover muxes
//
// What this block does
// - Engine makes serial clock itself, samples ADC data in clock-high state.
// - Bus goes to host only after all results stored and final state reached.
// - Memory data is host word when select is 0, conversion word when 1.
// - Owner select is 1 while engine active, 0 once complete.
// - Memory data lines driven when memory_side_drive is 1, else inputs.
// - memory_side_drive = adc_drive_enable or host write with a chip select low.
// - Host data lines drive only on host read with a chip select low.
// - Memory address is capture counter when select is 1, host address when 0.
// - Counter loads channel start offset, increments after each stored word.
// - Channel stops when counter reaches that channel's upper address.
// - SRAM select follows engine select while owned; engine pulls select and write low.
// - SRAM write strobe follows engine write when owned, host write pin otherwise.
// - SRAM output enable follows engine read when owned; engine reads low on store.
// - With select 0, SRAM select passes host SRAM select pin through.
// - Conversion word is 16 bits: 12 data, three zeros, overflow, shifted in.
`timescale 1ns/1ps
`include "adc_bus_consts.svh"
module adc_sram_bus_handover (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Capture control
  input wire logic capture_start,
  output logic capture_busy,
  // ADC serial link
  output logic adc_sclk,
  input wire logic adc_dout,
  // Host bus
  input wire logic [`DATA_W-1:0] host_data_in,
  output logic [`DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  input wire logic [`ADDR_W:1] host_address_lines,
  input wire logic host_flash_select,
  input wire logic host_sram_select_pin,
  input wire logic host_write_pin,
  input wire logic host_read_pin,
  // SRAM and flash bus
  input wire logic [`DATA_W-1:0] mem_data_in,
  output logic [`DATA_W-1:0] mem_data_out,
  output logic mem_data_oe,
  output logic [`ADDR_W:1] memory_address_lines,
  output logic sram_select_out,
  output logic sram_write_out,
  output logic sram_read_out
);
  // ***************************************
  // Reset release
  // ***************************************
  // Release is retimed to the clock; assertion stays asynchronous
  logic rst_meta_q, rst_n;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ***************************************
  // Capture engine
  // ***************************************
  // State of one capture run
  adc_bus_pkg::cap_state_e state_q, state_d;
  logic [`DATA_W-1:0] shift_q, shift_d;
  logic [`BIT_COUNT_W-1:0] bit_q, bit_d;
  logic [`CH_COUNT_W-1:0] ch_q, ch_d;
  logic [`ADDR_W-1:0] capture_address_counter, addr_d;
  logic bus_owner_select, owner_d;
  logic adc_drive_enable, drive_d;
  logic sclk_d;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [`DATA_W-1:0] conversion_word;
  logic [`ADDR_W-1:0] ch_top;
  logic engine_sram_select_n, engine_write_n, engine_read_n;

  // ***************************************
  // Channel address windows
  // ***************************************
  // Each channel owns a fixed window; its last slot ends that channel
  logic [`ADDR_W-1:0] ch_start_tbl [`CH_COUNT];
  logic [`ADDR_W-1:0] ch_upper_tbl [`CH_COUNT];
  genvar gi;
  generate
    for (gi = 0; gi < `CH_COUNT; gi++)
    begin : g_ch_window
      assign ch_start_tbl[gi] = (`ADDR_W)'(gi) * `CH_SPAN;
      assign ch_upper_tbl[gi] = ch_start_tbl[gi] + `CH_TOP;
    end
  endgenerate

  always_comb
  begin
    ch_top = ch_upper_tbl[ch_q];
  end

  // ***************************************
  // Capture sequencer
  // ***************************************

  // Words leave the shifter through the FIFO; a full FIFO stalls the shifter
  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    bit_d = bit_q;
    ch_d = ch_q;
    addr_d = capture_address_counter;
    owner_d = bus_owner_select;
    drive_d = adc_drive_enable;
    sclk_d = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_pop = 1'b0;
    case (state_q)
      adc_bus_pkg::ST_IDLE:
      begin
        if (capture_start)
        begin
          ch_d = `CH_FIRST;
          addr_d = ch_start_tbl[`CH_FIRST];
          bit_d = '0;
          owner_d = 1'b1;
          drive_d = 1'b1;
          state_d = adc_bus_pkg::ST_LOW;
        end
      end
      adc_bus_pkg::ST_LOW:
      begin
        // Serial clock rises on this edge
        sclk_d = 1'b1;
        state_d = adc_bus_pkg::ST_HIGH;
      end
      adc_bus_pkg::ST_HIGH:
      begin
        // Bit taken on the edge that ends the clock-high cycle
        shift_d = {shift_q[`DATA_W-2:0], adc_dout};
        bit_d = bit_q + 1'b1;
        state_d = (bit_q == `BIT_LAST) ? adc_bus_pkg::ST_WAIT : adc_bus_pkg::ST_LOW;
      end
      adc_bus_pkg::ST_WAIT:
      begin
        // Full word offered; a full buffer holds the shifter here
        fifo_in_valid = 1'b1;
        if (fifo_in_ready)
          state_d = adc_bus_pkg::ST_STORE;
      end
      adc_bus_pkg::ST_STORE:
      begin
        if (fifo_out_valid)
        begin
          // Pop drives the store strobes at the current counter
          fifo_pop = 1'b1;
          if (capture_address_counter == ch_top)
          begin
            if (ch_q == `CH_LAST)
              state_d = adc_bus_pkg::ST_DONE;
            else
            begin
              ch_d = ch_q + 1'b1;
              addr_d = ch_start_tbl[ch_d];
              state_d = adc_bus_pkg::ST_LOW;
            end
          end
          else
          begin
            addr_d = capture_address_counter + `ADDR_ONE;
            state_d = adc_bus_pkg::ST_LOW;
          end
        end
      end
      adc_bus_pkg::ST_DONE:
      begin
        // Last word is on the pins now; host gets the muxes next
        owner_d = 1'b0;
        drive_d = 1'b0;
        state_d = adc_bus_pkg::ST_IDLE;
      end
      default:
        state_d = adc_bus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= adc_bus_pkg::ST_IDLE;
      shift_q <= '0;
      bit_q <= '0;
      ch_q <= `CH_FIRST;
      capture_address_counter <= `ADDR_ZERO;
      // Host owns the bus out of reset
      bus_owner_select <= 1'b0;
      adc_drive_enable <= 1'b0;
      adc_sclk <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_q <= bit_d;
      ch_q <= ch_d;
      capture_address_counter <= addr_d;
      bus_owner_select <= owner_d;
      adc_drive_enable <= drive_d;
      adc_sclk <= sclk_d;
    end
  end

  // ***************************************
  // Sample buffer
  // ***************************************
  // Decouples the shifter from the store cycle
  sample_fifo #(
    .WIDTH(`DATA_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(shift_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(conversion_word)
  );

  // ***************************************
  // Engine strobes
  // ***************************************
  // Select, write and read low together for the cycle a word is popped
  always_comb
  begin
    engine_sram_select_n = !fifo_pop;
    engine_write_n = !fifo_pop;
    engine_read_n = !fifo_pop;
  end

  // ***************************************
  // Bus muxes, registered onto the pins
  // ***************************************
  logic host_cs_any;
  logic side_d, read_d, sel_d, wr_d, rd_d;
  logic [`DATA_W-1:0] mdata_d;
  logic [`ADDR_W:1] maddr_d;
  always_comb
  begin
    // Either host select low counts as a host cycle
    host_cs_any = !host_flash_select || !host_sram_select_pin;
    side_d = adc_drive_enable || (!host_write_pin && host_cs_any);
    read_d = !host_read_pin && host_cs_any;
    mdata_d = bus_owner_select ? conversion_word : host_data_in;
    maddr_d = bus_owner_select ? capture_address_counter : host_address_lines;
    sel_d = bus_owner_select ? engine_sram_select_n : host_sram_select_pin;
    wr_d = bus_owner_select ? engine_write_n : host_write_pin;
    rd_d = bus_owner_select ? engine_read_n : host_read_pin;
  end

  // ***************************************
  // Pin registers
  // ***************************************
  // Every pin leaves a flop, so host pass-through lags by one cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_data_out <= '0;
      mem_data_oe <= 1'b0;
      host_data_out <= '0;
      host_data_oe <= 1'b0;
      memory_address_lines <= '0;
      sram_select_out <= 1'b1;
      sram_write_out <= 1'b1;
      sram_read_out <= 1'b1;
      capture_busy <= 1'b0;
    end
    else if (clk_en)
    begin
      mem_data_out <= mdata_d;
      mem_data_oe <= side_d;
      host_data_out <= mem_data_in;
      host_data_oe <= read_d;
      memory_address_lines <= maddr_d;
      sram_select_out <= sel_d;
      sram_write_out <= wr_d;
      sram_read_out <= rd_d;
      // Busy lags the owner select, in step with the muxed pins
      capture_busy <= bus_owner_select;
    end
  end
endmodule

// [tb/sram_model.sv]
// Behavioural SRAM on the memory side of the handover block
`timescale 1ns/1ps
`include "adc_bus_consts.svh"
module sram_model (
  // Clock
  input wire logic clk_sys,
  // SRAM pins
  input wire logic sram_select_out,
  input wire logic sram_write_out,
  input wire logic sram_read_out,
  input wire logic [`ADDR_W:1] memory_address_lines,
  input wire logic [`DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  output logic [`DATA_W-1:0] mem_data_in
);
  logic [`DATA_W-1:0] mem [logic [`ADDR_W:1]];
  logic [`DATA_W-1:0] last_q = 16'h0000;
  logic rd;
  // Undriven bus shows the inverse of the last word
  always @(sram_select_out, sram_read_out, mem_data_oe, memory_address_lines, last_q)
  begin
    rd = !sram_select_out && !sram_read_out && !mem_data_oe;
    if (rd && mem.exists(memory_address_lines))
      mem_data_in = mem[memory_address_lines];
    else
      mem_data_in = ~last_q;
  end
  always @(posedge clk_sys)
  begin
    if (!sram_select_out && !sram_write_out)
      mem[memory_address_lines] = mem_data_oe ? mem_data_out : 'x;
    if (rd)
      last_q = mem_data_in;
  end
endmodule

// [tb/adc_sram_bus_handover_assertions.sv]
// Port checker for the SRAM handover block
`timescale 1ns/1ps
`include "adc_bus_consts.svh"
module handover_checker (
  // Clock and control
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic capture_start,
  input wire logic capture_busy,
  input wire logic adc_sclk,
  // Host pins
  input wire logic [`ADDR_W:1] host_address_lines,
  input wire logic host_flash_select,
  input wire logic host_sram_select_pin,
  input wire logic host_write_pin,
  input wire logic host_read_pin,
  input wire logic host_data_oe,
  // Memory pins
  input wire logic mem_data_oe,
  input wire logic [`ADDR_W:1] memory_address_lines,
  input wire logic sram_select_out,
  input wire logic sram_write_out,
  input wire logic sram_read_out
);
  logic sel_q;
  logic [`ADDR_W:1] stores_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Counts engine stores within one run
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      sel_q <= 1'b1;
      stores_q <= `ADDR_ZERO;
    end
    else
    begin
      sel_q <= sram_select_out;
      if (!capture_busy)
        stores_q <= `ADDR_ZERO;
      else if (sel_q && !sram_select_out)
        stores_q <= stores_q + `ADDR_ONE;
    end
  a_reset_idle: assert property (disable iff (1'b0)
    !reset_n ##1 !reset_n |-> !capture_busy && sram_select_out && sram_write_out
    && !mem_data_oe)
    else $error("outputs not idle in reset");
  a_busy_drives: assert property (capture_busy |-> mem_data_oe)
    else $error("memory data not driven while busy");
  a_store_strobes: assert property (capture_busy && !sram_write_out |->
    !sram_select_out && !sram_read_out) else $error("store strobes disagree");
  a_store_single: assert property (capture_busy && !sram_select_out && clk_en |=>
    sram_select_out) else $error("store select longer than one cycle");
  a_store_address: assert property (capture_busy && sel_q && !sram_select_out |->
    memory_address_lines == stores_q) else $error("store address wrong");
  a_store_count: assert property ($fell(capture_busy) |-> stores_q == 23'h000040)
    else $error("run ended with wrong store count");
  a_host_read: assert property (clk_en |=> host_data_oe == (!$past(host_read_pin)
    && !($past(host_flash_select) && $past(host_sram_select_pin))))
    else $error("host data drive wrong");
  a_host_pass: assert property (clk_en ##1 !capture_busy |->
    memory_address_lines == $past(host_address_lines) && sram_write_out
    == $past(host_write_pin) && sram_select_out == $past(host_sram_select_pin))
    else $error("host pass-through wrong");
  a_sclk_pulse: assert property (adc_sclk && clk_en |=> !adc_sclk)
    else $error("serial clock high too long");
endmodule
bind adc_sram_bus_handover handover_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .clk_en(clk_en), .capture_start(capture_start), .capture_busy(capture_busy),
  .adc_sclk(adc_sclk), .host_address_lines(host_address_lines),
  .host_flash_select(host_flash_select), .host_sram_select_pin(host_sram_select_pin),
  .host_write_pin(host_write_pin), .host_read_pin(host_read_pin),
  .host_data_oe(host_data_oe), .mem_data_oe(mem_data_oe),
  .memory_address_lines(memory_address_lines), .sram_select_out(sram_select_out),
  .sram_write_out(sram_write_out), .sram_read_out(sram_read_out));

// [tb/adc_sram_bus_handover_tb.sv]
// Testbench for the SRAM capture and handover block
`timescale 1ns/1ps
`include "adc_bus_consts.svh"
module adc_sram_bus_handover_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic capture_start = 1'b0;
  logic adc_dout = 1'b0;
  logic used = 1'b0;
  logic host_flash_select = 1'b1;
  logic host_sram_select_pin = 1'b1;
  logic host_write_pin = 1'b1;
  logic host_read_pin = 1'b1;
  logic [`DATA_W-1:0] host_data_in = 16'h0000;
  logic [`ADDR_W:1] host_address_lines = 23'h000000;
  logic [`DATA_W-1:0] mem_data_in, host_data_out, mem_data_out, word;
  logic [`ADDR_W:1] memory_address_lines;
  logic capture_busy, adc_sclk, host_data_oe, mem_data_oe;
  logic sram_select_out, sram_write_out, sram_read_out;
  logic [3:0] p;
  logic [`DATA_W-1:0] exp_q[$];
  int n_errors = 0;
  int checked = 0;
  int bi = 0;
  int n;
  always #50 clk_sys = ~clk_sys;
  adc_sram_bus_handover DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .capture_start(capture_start), .capture_busy(capture_busy), .adc_sclk(adc_sclk),
    .adc_dout(adc_dout), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_address_lines(host_address_lines),
    .host_flash_select(host_flash_select), .host_sram_select_pin(host_sram_select_pin),
    .host_write_pin(host_write_pin), .host_read_pin(host_read_pin),
    .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
    .memory_address_lines(memory_address_lines), .sram_select_out(sram_select_out),
    .sram_write_out(sram_write_out), .sram_read_out(sram_read_out));
  sram_model u_sram (.clk_sys(clk_sys), .sram_select_out(sram_select_out),
    .sram_write_out(sram_write_out), .sram_read_out(sram_read_out),
    .memory_address_lines(memory_address_lines), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in));
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("n_errors=%0d checked=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Pins are {flash, sram, write, read}, all active low
  task automatic host_op(input logic [3:0] pins, input logic [22:0] a);
    @(negedge clk_sys);
    {host_flash_select, host_sram_select_pin, host_write_pin, host_read_pin} = pins;
    host_address_lines = a;
    host_data_in = 16'($urandom);
    repeat (3) @(negedge clk_sys);
  endtask
  // ADC source: a bit moves on once a serial clock high has passed
  always @(negedge clk_sys)
  begin
    if (adc_sclk === 1'b1)
      used = 1'b1;
    else if (used)
    begin
      used = 1'b0;
      bi = bi + 1;
      if (bi == 16)
      begin
        exp_q.push_back(word);
        word = 16'($urandom) & 16'hfff1;
        bi = 0;
      end
    end
    adc_dout = word[15 - bi];
  end
  initial
  begin
    void'($urandom(7));
    word = 16'($urandom) & 16'hfff1;
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check({capture_busy, mem_data_oe, sram_select_out}, 3'b001);
    capture_start = 1'b1;
    @(negedge clk_sys);
    capture_start = 1'b0;
    @(negedge clk_sys);
    check(capture_busy, 1'b1);
    for (n = 0; n < 20000 && capture_busy !== 1'b0; n++)
    begin
      clk_en = ($urandom % 4) != 0;
      capture_start = (n == 100);
      @(negedge clk_sys);
    end
    clk_en = 1'b1;
    if (n == 20000)
      n_errors++;
    else
    begin
      check(64'(exp_q.size()), 64'd64);
      for (n = 0; n < 64; n++)
        check(u_sram.mem[23'(n)], exp_q[n]);
      for (n = 0; n < 64; n++)
      begin
        host_op(4'b1010, 23'(n));
        check({host_data_oe, host_data_out}, {1'b1, exp_q[n]});
      end
      for (n = 0; n < 16; n++)
      begin
        p = 4'(n);
        host_op(p, 23'($urandom) | 23'h000040);
        check({mem_data_oe, host_data_oe, sram_select_out, sram_write_out, sram_read_out},
          {!p[1] && !(p[3] && p[2]), !p[0] && !(p[3] && p[2]), p[2], p[1], p[0]});
        check({memory_address_lines, mem_data_out}, {host_address_lines, host_data_in});
      end
    end
    end_of_test();
  end
endmodule
